// ==== logic/spc_defines.vh ====
// Purpose: Shared constants for the serial coding channel and its compensation buffer.
// Assumes: Included by bare name from the channel design file; the FIFO design file does not include it.
// Notes: Ten-bit characters hold bit 9 as the first bit in time.
// How it works
// [R1] Received words are optionally inverted before alignment and decoding.
// [R2] A comma found in a two-word window fixes the character boundary offset.
// [R3] Aligned ten-bit characters are decoded to byte plus control flag.
// [R4] Decoded characters pass a compensation buffer toward the core side.
// [R5] Core bytes are encoded into ten-bit characters.
// [R6] Encoded characters are optionally inverted and handed to the serializer.
// [R7] Bypass mode skips coding, giving raw eight- or ten-bit transfers.
// [R8] Half-rate mode pairs two characters into one double-width core word.
// [R9] Channel and coding settings are writable through a small register port.
// [R10] Skip characters are dropped when the buffer runs high, repeated when low.
// [R11] In half-rate words the earlier character sits in the lower half.
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// Config port addresses
`define SPC_CTRL_ADDR 2'h0
`define SPC_STAT_ADDR 2'h1

// Control register bits and reset value (alignment enabled)
`define SPC_CTL_RXINV 0
`define SPC_CTL_TXINV 1
`define SPC_CTL_BYPASS 2
`define SPC_CTL_RAW10 3
`define SPC_CTL_HALF 4
`define SPC_CTL_ALIGN 5
`define SPC_CTRL_RST 8'h20

// Status register bits
`define SPC_ST_LOCK 0
`define SPC_ST_DERR 1
`define SPC_ST_CERR 2
`define SPC_ST_OVF 3

// Character constants: {k, byte} for skip and idle, seven-bit comma prefixes
`define SPC_SKIP 9'h11c
`define SPC_IDLE 9'h1bc
`define SPC_COMMA_POS 7'h1f
`define SPC_COMMA_NEG 7'h60

// Compensation buffer marks
`define SPC_FIFO_DEPTH 8
`define SPC_FIFO_HI 4'h6
`define SPC_FIFO_LO 4'h2

`endif

// ==== logic/spc_fifo.v ====
// Purpose: Small flip-flop FIFO with valid/ready on both sides and a fill level.
// Assumes: Single clock; synchronous active-high reset.
// Notes: Depth must be a power of two matching AW.
`timescale 1ns/10ps
`default_nettype none
module spc_fifo #(
  parameter W = 12,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW:0] level
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rptr_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
    if (sys_rst) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // spc_fifo
`default_nettype wire

// ==== logic/spc_pcs_channel.v ====
// Purpose: One serial coding channel: align, decode, compensate on receive; encode on transmit.
// Assumes: Link clocks are slow against clock and are sampled as ordinary inputs.
// Notes: Deserializer data must be stable around each rising receive clock edge.
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.vh"
module spc_pcs_channel #(
  parameter FIFO_AW = 3
) (
  input wire clock,
  input wire sys_rst,
  input wire rx_clk_link,
  input wire [9:0] rx_word,
  input wire tx_clk_link,
  output reg [9:0] tx_char_r,
  input wire cfg_we,
  input wire [1:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata_r,
  output reg [23:0] rx_data_r,
  output reg rx_valid_r,
  input wire rx_ready,
  input wire [23:0] tx_data,
  input wire tx_valid,
  output reg tx_ready_r,
  output reg rx_locked_r
);
  // Six-bit codes in negative disparity form, code n in bits 6n+5 down to 6n
  localparam [191:0] code6_tab = {
    6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
    6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27
  };

  function [3:0] tab4;
    input [2:0] y;
    begin
      case (y)
        3'd0: tab4 = 4'b1011;
        3'd1: tab4 = 4'b1001;
        3'd2: tab4 = 4'b0101;
        3'd3: tab4 = 4'b1100;
        3'd4: tab4 = 4'b1101;
        3'd5: tab4 = 4'b1010;
        3'd6: tab4 = 4'b0110;
        default: tab4 = 4'b1110;
      endcase
    end
  endfunction

  function [3:0] ones;
    input [5:0] v;
    integer n;
    begin
      ones = 4'h0;
      for (n = 0; n < 6; n = n + 1) begin
        ones = ones + {3'h0, v[n]};
      end
    end
  endfunction

  // Returns {running disparity after, abcdei, fghj}
  function [10:0] enc;
    input [8:0] kd;
    input rd;
    reg [5:0] s6;
    reg [3:0] s4;
    reg rm;
    reg alt;
    reg [4:0] x;
    begin
      x = kd[4:0];
      s6 = kd[8] && (x == 5'd28) ? 6'b001111 : code6_tab[x*6 +: 6];
      if (rd && (ones(s6) != 4'h3 || x == 5'd7)) begin
        s6 = ~s6;
      end
      rm = rd ^ (ones(s6) != 4'h3);
      alt = (kd[7:5] == 3'd7) && (kd[8] || (!rm && (x == 5'd17 || x == 5'd18 || x == 5'd20))
            || (rm && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
      s4 = alt ? 4'b0111 : tab4(kd[7:5]);
      // After a 110000 six-bit block, K28.1, .2, .5 and .6 take the opposite four-bit form from data characters
      if ((rm && (ones({2'b00, s4}) != 4'h2 || kd[7:5] == 3'd3))
          || (!rm && kd[8] && x == 5'd28 && ones({2'b00, s4}) == 4'h2 && kd[7:5] != 3'd3)) begin
        s4 = ~s4;
      end
      enc = {rm ^ (ones({2'b00, s4}) != 4'h2), s6, s4};
    end
  endfunction

  // Returns {code err, disparity err, disparity after, k, byte}
  function [11:0] dec;
    input [9:0] c;
    input rd;
    integer i;
    reg [8:0] kd;
    reg [10:0] e0;
    reg [10:0] e1;
    reg ok;
    begin
      dec = {2'b10, rd, 9'h000};
      for (i = 0; i < 512; i = i + 1) begin
        kd = i[8:0];
        ok = !kd[8] || kd[4:0] == 5'd28 || (kd[7:5] == 3'd7 && (kd[4:0] == 5'd23
             || kd[4:0] == 5'd27 || kd[4:0] == 5'd29 || kd[4:0] == 5'd30));
        e0 = enc(kd, rd);
        e1 = enc(kd, ~rd);
        if (ok && e0[9:0] == c) begin
          dec = {2'b00, e0[10], kd};
        end else if (ok && e1[9:0] == c && dec[11]) begin
          dec = {2'b01, e1[10], kd};
        end
      end
    end
  endfunction

  reg [7:0] ctrl_r;
  reg [3:0] stat_r;
  reg [2:0] rxc_s_r;
  reg [2:0] txc_s_r;
  reg [9:0] rxw_m_r;
  reg [9:0] rxw_s_r;
  reg [19:0] win_r;
  reg stb_r;
  reg [3:0] off_r;
  reg rd_r;
  reg trd_r;
  reg ins_done_r;
  reg half_r;
  reg [11:0] low_r;
  reg [23:0] hold_r;
  reg [1:0] hold_cnt_r;
  reg [1:0] hold_cnt_nxt;
  reg [3:0] found;
  reg hit;
  reg [9:0] cand;
  reg [11:0] entry;
  wire coded = !ctrl_r[`SPC_CTL_BYPASS];
  wire half = ctrl_r[`SPC_CTL_HALF];
  wire rx_edge = rxc_s_r[1] && !rxc_s_r[2];
  wire tx_fall = txc_s_r[2] && !txc_s_r[1];
  wire [3:0] off_sel = hit ? found : off_r;
  wire [9:0] achar = win_r[5'd19 - {1'b0, off_sel} -: 10];
  wire [11:0] dres = dec(achar, rd_r);
  wire [FIFO_AW:0] level;
  wire f_in_ready;
  wire f_out_valid;
  wire [11:0] f_out;
  wire is_skip_in = coded && (entry[8:0] == `SPC_SKIP);
  wire wr_v = stb_r && !(is_skip_in && level >= `SPC_FIFO_HI); // R10
  wire take = f_out_valid && (!rx_valid_r || rx_ready);
  wire ins = coded && !ins_done_r && (f_out[8:0] == `SPC_SKIP)
             && (level <= `SPC_FIFO_LO); // R10
  wire pop = take && !ins;
  wire tx_acc = tx_valid && tx_ready_r;
  wire [11:0] tsym = (hold_cnt_r != 2'd0) ? hold_r[11:0] : coded ? {3'h0, `SPC_IDLE} : 12'h000;
  wire [10:0] tenc = enc(tsym[8:0], trd_r);

  always @* begin
    found = 4'h0;
    hit = 1'b0;
    cand = 10'h000;
    for (found = 4'h0; found < 4'd10 && !hit; found = found + 4'h1) begin
      cand = win_r[5'd19 - {1'b0, found} -: 10];
      hit = ctrl_r[`SPC_CTL_ALIGN] && (cand[9:3] == `SPC_COMMA_POS
            || cand[9:3] == `SPC_COMMA_NEG); // R2
    end
    if (hit) begin
      found = found - 4'h1;
    end
  end

  // Kept apart from the comma search so the decode path cannot feed back into it
  always @* begin
    if (coded) begin
      entry = {dres[11] | dres[10], 2'b00, dres[8:0]}; // R3
    end else if (ctrl_r[`SPC_CTL_RAW10]) begin
      entry = {2'b00, achar}; // R7
    end else begin
      entry = {4'h0, achar[7:0]}; // R7
    end
    hold_cnt_nxt = hold_cnt_r;
    if (tx_acc) begin
      hold_cnt_nxt = half ? 2'd2 : 2'd1;
    end else if (tx_fall && hold_cnt_r != 2'd0) begin
      hold_cnt_nxt = hold_cnt_r - 2'd1;
    end
  end

  spc_fifo #(
    .W(12),
    .D(`SPC_FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_clock_tolerance_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(wr_v),
    .in_ready(f_in_ready),
    .in_data(entry),
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data(f_out),
    .level(level)
  ); // R4

  always @(posedge clock) begin
    rxc_s_r <= {rxc_s_r[1:0], rx_clk_link};
    txc_s_r <= {txc_s_r[1:0], tx_clk_link};
    rxw_m_r <= rx_word;
    rxw_s_r <= rxw_m_r;
    if (sys_rst) begin
      ctrl_r <= `SPC_CTRL_RST;
      stat_r <= 4'h0;
      cfg_rdata_r <= 8'h00;
      win_r <= 20'h00000;
      stb_r <= 1'b0;
      off_r <= 4'h0;
      rd_r <= 1'b0;
      trd_r <= 1'b0;
      ins_done_r <= 1'b0;
      half_r <= 1'b0;
      low_r <= 12'h000;
      rx_data_r <= 24'h000000;
      rx_valid_r <= 1'b0;
      hold_r <= 24'h000000;
      hold_cnt_r <= 2'd0;
      tx_ready_r <= 1'b0;
      tx_char_r <= 10'h000;
      rx_locked_r <= 1'b0;
    end else begin
      stb_r <= rx_edge;
      if (rx_edge) begin
        win_r <= {win_r[9:0], rxw_s_r ^ {10{ctrl_r[`SPC_CTL_RXINV]}}}; // R1
      end
      if (stb_r && hit) begin
        off_r <= found; // R2
        rx_locked_r <= 1'b1;
      end
      if (stb_r && coded) begin
        rd_r <= dres[9];
      end
      // Sticky status bits 3:1: W1C at the status address, a new event wins; the lock bit follows rx_locked_r
      stat_r[`SPC_ST_LOCK] <= rx_locked_r;
      stat_r[3:1] <= (cfg_we && cfg_addr == `SPC_STAT_ADDR) ? stat_r[3:1] & ~cfg_wdata[3:1]
                     : stat_r[3:1];
      if (stb_r && coded && dres[10]) begin
        stat_r[`SPC_ST_DERR] <= 1'b1;
      end
      if (stb_r && coded && dres[11]) begin
        stat_r[`SPC_ST_CERR] <= 1'b1;
      end
      if (wr_v && !f_in_ready) begin
        stat_r[`SPC_ST_OVF] <= 1'b1;
      end
      if (cfg_we && cfg_addr == `SPC_CTRL_ADDR) begin
        ctrl_r <= cfg_wdata; // R9
        rx_locked_r <= 1'b0;
        half_r <= 1'b0;
      end
      cfg_rdata_r <= (cfg_addr == `SPC_CTRL_ADDR) ? ctrl_r
                     : (cfg_addr == `SPC_STAT_ADDR) ? {4'h0, stat_r} : 8'h00; // R9
      if (take) begin
        ins_done_r <= ins;
      end
      if (rx_valid_r && rx_ready) begin
        rx_valid_r <= 1'b0;
      end
      if (take && half && !half_r) begin
        low_r <= f_out;
        half_r <= 1'b1;
      end else if (take && half) begin
        rx_data_r <= {f_out, low_r}; // R8 R11
        rx_valid_r <= 1'b1;
        half_r <= 1'b0;
      end else if (take) begin
        rx_data_r <= {12'h000, f_out};
        rx_valid_r <= 1'b1;
      end
      if (tx_acc) begin
        hold_r <= half ? tx_data : {12'h000, tx_data[11:0]}; // R8 R11
      end else if (tx_fall && hold_cnt_r != 2'd0) begin
        hold_r <= {12'h000, hold_r[23:12]};
      end
      hold_cnt_r <= hold_cnt_nxt;
      tx_ready_r <= (hold_cnt_nxt == 2'd0);
      if (tx_fall && coded) begin
        tx_char_r <= tenc[9:0] ^ {10{ctrl_r[`SPC_CTL_TXINV]}}; // R5 R6
        trd_r <= tenc[10];
      end else if (tx_fall) begin
        tx_char_r <= (ctrl_r[`SPC_CTL_RAW10] ? tsym[9:0] : {2'b00, tsym[7:0]})
                     ^ {10{ctrl_r[`SPC_CTL_TXINV]}}; // R7 R6
      end
    end
  end
endmodule // spc_pcs_channel
`default_nettype wire

// ==== test/spc_pcs_channel_props.sv ====
// Purpose: Port-level assertions for the serial coding channel.
// Assumes: One clock domain; link clocks are plain sampled inputs.
// Notes: Timing figures follow the hand-over contract of the channel.
`timescale 1ns/10ps
`default_nettype none
module spc_pcs_channel_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tx_clk_link,
  input wire logic [9:0] tx_char_r,
  input wire logic cfg_we,
  input wire logic [1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_r,
  input wire logic [23:0] rx_data_r,
  input wire logic rx_valid_r,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready_r,
  input wire logic rx_locked_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_RX_HOLD: assert property (rx_valid_r && !rx_ready |=> rx_valid_r && $stable(rx_data_r))
    else $error("receive word changed before accept");
  AST_TX_TAKEN: assert property (tx_valid && tx_ready_r |=> !tx_ready_r)
    else $error("transmit ready stayed high after accept");
  AST_TX_CHAR_EDGE: assert property ($changed(tx_char_r) |-> !$past(tx_clk_link))
    else $error("transmit character changed with link clock high");
  AST_TX_CHAR_HOLD: assert property ($changed(tx_char_r) |=> $stable(tx_char_r) [*8])
    else $error("transmit character held too briefly");
  AST_TX_READY_BACK: assert property ($fell(tx_ready_r) |-> ##[1:100] tx_ready_r)
    else $error("transmit ready did not return");
  AST_CFG_UNMAPPED: assert property (cfg_addr[1] |=> cfg_rdata_r == 8'h00)
    else $error("unmapped config address read nonzero");
  AST_CFG_READBACK: assert property (cfg_we && cfg_addr == 2'h0 ##1 !cfg_we && cfg_addr == 2'h0
    |=> cfg_rdata_r == $past(cfg_wdata, 2))
    else $error("control readback differs from write");
  AST_LOCK_HELD: assert property (rx_locked_r && !(cfg_we && cfg_addr == 2'h0) |=> rx_locked_r)
    else $error("lock lost without control write");
  cover property (tx_valid && tx_ready_r);
  cover property (rx_valid_r && rx_ready);
  cover property ($rose(rx_locked_r));
endmodule // spc_pcs_channel_props
bind spc_pcs_channel spc_pcs_channel_props spc_pcs_channel_props_i (.clock(clock),
  .sys_rst(sys_rst), .tx_clk_link(tx_clk_link), .tx_char_r(tx_char_r), .cfg_we(cfg_we),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r),
  .rx_data_r(rx_data_r), .rx_valid_r(rx_valid_r), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_ready_r(tx_ready_r), .rx_locked_r(rx_locked_r));
`default_nettype wire

// ==== test/spc_link_model.sv ====
// Purpose: Far-side model: deserializer words in, serializer characters captured.
// Assumes: Both link clocks run at 125 ns; the transmit clock lags the receive clock by 23 ns.
// Notes: Idle is a comma character of alternating disparity; queued data must be neutral.
`timescale 1ns/10ps
`default_nettype none
module spc_link_model (
  output logic rx_clk_link,
  output logic [9:0] rx_word,
  output logic tx_clk_link,
  input wire logic [9:0] tx_char_r
);
  logic [9:0] rxq[$];
  logic [9:0] seen[$];
  logic rd_pos = 1'b1;
  logic inv = 1'b0;
  initial begin
    rx_clk_link = 1'b0;
    rx_word = 10'h0fa;
    forever #62.5 rx_clk_link = ~rx_clk_link;
  end
  initial begin
    tx_clk_link = 1'b0;
    #23;
    forever #62.5 tx_clk_link = ~tx_clk_link;
  end
  // Words move on the falling edge so they are stable around the rising one
  always @(negedge rx_clk_link) begin
    if (rxq.size() > 0) begin
      rx_word <= rxq.pop_front() ^ {10{inv}};
    end else begin
      rx_word <= (rd_pos ? 10'h305 : 10'h0fa) ^ {10{inv}};
      rd_pos <= ~rd_pos;
    end
  end
  // Idle and blank characters are not recorded
  always @(posedge tx_clk_link) begin
    if (tx_char_r !== 10'h000 && tx_char_r !== 10'h0fa && tx_char_r !== 10'h305) begin
      seen.push_back(tx_char_r);
    end
  end
endmodule // spc_link_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the serial coding channel.
// Assumes: Link model supplies both link clocks and idle traffic.
// Notes: Inputs change 1 ns after the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, sys_rst, cfg_we, rx_ready, tx_valid, rx_clk_link, tx_clk_link;
  logic rx_valid_r, tx_ready_r, rx_locked_r;
  logic [1:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata_r, d;
  logic [23:0] tx_data, rx_data_r;
  logic [9:0] rx_word, tx_char_r;
  int errors = 0;
  int n_tests = 0;
  spc_pcs_channel spc_pcs_channel_i (.clock(clock), .sys_rst(sys_rst),
    .rx_clk_link(rx_clk_link), .rx_word(rx_word), .tx_clk_link(tx_clk_link),
    .tx_char_r(tx_char_r), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_r(cfg_rdata_r), .rx_data_r(rx_data_r), .rx_valid_r(rx_valid_r),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready_r(tx_ready_r),
    .rx_locked_r(rx_locked_r));
  spc_link_model spc_link_model_i (.rx_clk_link(rx_clk_link), .rx_word(rx_word),
    .tx_clk_link(tx_clk_link), .tx_char_r(tx_char_r));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic stop_test;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wcfg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock) #1 cfg_we = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    @(posedge clock) #1 cfg_we = 1'b0;
  endtask
  task automatic rcfg(input logic [1:0] a);
    @(posedge clock) #1 cfg_addr = a;
    @(posedge clock) #1 d = cfg_rdata_r;
  endtask
  task automatic rx_expect(input logic [23:0] exp);
    int i;
    for (i = 0; i < 400 && !(rx_valid_r === 1'b1 && rx_data_r !== 24'h0001bc); i++) begin
      @(posedge clock);
      #1;
    end
    chk(rx_data_r, exp);
  endtask
  task automatic tx_case(input logic [7:0] ctl, input logic [23:0] v, input logic [9:0] e0,
    input logic [9:0] e1, input int n);
    int i;
    wcfg(2'h0, ctl);
    repeat (40) @(posedge clock);
    spc_link_model_i.seen.delete();
    @(posedge clock) #1 tx_valid = 1'b1;
    tx_data = v;
    while (tx_ready_r !== 1'b1) @(posedge clock) #1;
    @(posedge clock) #1 tx_valid = 1'b0;
    for (i = 0; i < 300 && spc_link_model_i.seen.size() < n; i++) @(posedge clock);
    chk({14'h0, spc_link_model_i.seen[0]}, {14'h0, e0});
    if (n > 1) chk({14'h0, spc_link_model_i.seen[1]}, {14'h0, e1});
  endtask
  task automatic t_config;
    rcfg(2'h0);
    chk({16'h0, d}, 24'h000020);
    chk({23'h0, tx_ready_r}, 24'h000001);
    wcfg(2'h2, 8'hff);
    rcfg(2'h2);
    chk({16'h0, d}, 24'h000000);
  endtask
  task automatic t_receive;
    int i;
    for (i = 0; i < 400 && rx_locked_r !== 1'b1; i++) @(posedge clock) #1;
    chk({23'h0, rx_locked_r}, 24'h000001);
    repeat (100) @(posedge clock);
    spc_link_model_i.rxq.push_back(10'h2aa);
    rx_expect(24'h0000b5);
  endtask
  task automatic t_skip;
    repeat (60) @(posedge clock);
    // Pick the skip form that matches the disparity the idle stream has reached
    #1 spc_link_model_i.rxq.push_back(spc_link_model_i.rd_pos ? 10'h30b : 10'h0f4);
    rx_expect(24'h00011c);
    @(posedge clock) #1;
    chk({rx_valid_r, rx_data_r[22:0]}, {1'b1, 23'h00011c});
  endtask
  task automatic t_overflow;
    @(posedge clock) #1 rx_ready = 1'b0;
    repeat (250) @(posedge clock);
    rcfg(2'h1);
    chk({22'h0, d[3], d[0]}, 24'h000003);
    @(posedge clock) #1 rx_ready = 1'b1;
    repeat (60) @(posedge clock);
    wcfg(2'h1, 8'h08);
    rcfg(2'h1);
    chk({23'h0, d[3]}, 24'h000000);
  endtask
  task automatic t_invert_rx;
    spc_link_model_i.inv = 1'b1;
    wcfg(2'h0, 8'h21);
    repeat (150) @(posedge clock);
    spc_link_model_i.rxq.push_back(10'h2aa);
    rx_expect(24'h0000b5);
  endtask
  initial begin
    sys_rst = 1'b1;
    cfg_we = 1'b0;
    cfg_addr = 2'h0;
    cfg_wdata = 8'h00;
    rx_ready = 1'b1;
    tx_valid = 1'b0;
    tx_data = 24'h0;
    repeat (2) @(posedge clock);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clock);
    t_config();
    t_receive();
    t_skip();
    t_overflow();
    tx_case(8'h20, 24'h0000b5, 10'h2aa, 10'h0, 1);
    tx_case(8'h22, 24'h0000b5, 10'h155, 10'h0, 1);
    tx_case(8'h2c, 24'h0002a5, 10'h2a5, 10'h0, 1);
    tx_case(8'h24, 24'h0000a5, 10'h0a5, 10'h0, 1);
    tx_case(8'h3c, 24'h0c312a, 10'h12a, 10'h0c3, 2);
    t_invert_rx();
    stop_test();
  end
  initial begin
    #300000;
    errors++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
